/* rtl/adas_top.sv */
// Audio D/A and A/D sequencer: APB registers, speaker and mic data paths.
// Assumes DMA handshakes on pclk; converter ack and data arrive async.
// Notes on behaviour
// - Control bit 15 is software reset
// - Bit 4 enables mic path and DMA
// - Bit 0 enables speaker path and DMA
// - Reserved bits read zero; write zero
// - Mic two-page boundary sets flag, W1C
// - Mic one-page boundary sets flag, W1C
// - Sample over valid capture: overrun, overwrite
// - Move into mic DMA register sets flag
// - Speaker page boundaries set flags, W1C
// - Due sample without valid data after first refill: underrun
// - Output, refill from DMA stage, request
// - One speaker sample per conversion interval
// - Page flag stalls DMA until cleared
// - Unsettled reference delays start 5us+period
// - One A/D request per interval
// - Ack with data fills capture register
// - Capture to DMA stage, then memory
// - Disabled path shows valid flags zero
// - Stop select picks mic stall boundary
// - Three-bit rate code decode
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module adas_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic dac_vref_on,
   output logic adc_vref_on,
   output logic spk_dma_req,
   input wire logic spk_dma_ack,
   input wire logic [9:0] spk_dma_data,
   input wire logic spk_page1_evt,
   input wire logic spk_page2_evt,
   output logic [9:0] dac_data,
   output logic dac_load,
   output logic adc_request,
   input wire logic adc_ack,
   input wire logic [9:0] adc_data,
   output logic mic_dma_req,
   input wire logic mic_dma_ack,
   output logic [9:0] mic_dma_data,
   input wire logic mic_page1_evt,
   input wire logic mic_page2_evt
);
   localparam int TW = adas_pkg::TW;

   // Register state
   logic [15:0] ctrl, next_ctrl;
   logic [15:0] intr, next_intr;
   logic [15:0] cfg, next_cfg;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_irq;

   // Speaker state
   logic spk_out_valid, next_spk_out_valid;
   logic spk_dma_valid, next_spk_dma_valid;
   logic [9:0] spk_out_reg, next_spk_out_reg;
   logic [9:0] spk_dma_reg, next_spk_dma_reg;
   logic spk_primed, next_spk_primed;
   logic spk_run_q, next_spk_run_q;
   logic [TW-1:0] spk_cnt, next_spk_cnt;
   logic [TW-1:0] dvref_cnt, next_dvref_cnt;
   logic next_spk_dma_req, next_dac_load;
   logic [9:0] next_dac_data;

   // Mic state
   logic mic_capture_valid, next_mic_capture_valid;
   logic mic_dma_valid, next_mic_dma_valid;
   logic [9:0] mic_capture_reg, next_mic_capture_reg;
   logic [9:0] next_mic_dma_data;
   logic mic_run_q, next_mic_run_q;
   logic [TW-1:0] mic_cnt, next_mic_cnt;
   logic [TW-1:0] avref_cnt, next_avref_cnt;
   adas_pkg::adas_adc_t adc_st, next_adc_st;
   logic next_adc_request, next_mic_dma_req;
   logic ack_s1, ack_s2;
   logic [9:0] adat_s1, adat_s2;

   // Decoded controls
   logic srst, spk_run, mic_run, spk_stall, mic_stall;
   logic wr_en, rd_sel;
   logic [15:0] w1c;

   always_comb begin
      srst = ctrl[adas_pkg::CTRL_SRST_BIT];
      spk_run = ctrl[adas_pkg::CTRL_SEN_BIT] & ~srst;
      mic_run = ctrl[adas_pkg::CTRL_MEN_BIT] & ~srst;
      // Speaker requests wait while either speaker page flag is pending
      spk_stall = intr[adas_pkg::INT_SPG1_BIT] |
                  intr[adas_pkg::INT_SPG2_BIT];
      mic_stall = intr[adas_pkg::INT_MPG2_BIT] |
                  (cfg[adas_pkg::CFG_MSTOP_BIT] &
                   intr[adas_pkg::INT_MPG1_BIT]);
      wr_en = psel & penable & pready & pwrite;
      rd_sel = psel & ~penable;
      w1c = (wr_en && paddr == adas_pkg::INT_ADDR) ? pwdata[15:0] :
            16'h0000;
   end

   // APB slave: no wait state; pready is set in the setup cycle so that all answers come from flops
   always_comb begin
      next_ctrl = ctrl;
      next_cfg = cfg;
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (wr_en && paddr == adas_pkg::CTRL_ADDR) begin
         next_ctrl = 16'h0000;
         next_ctrl[adas_pkg::CTRL_SRST_BIT] =
            pwdata[adas_pkg::CTRL_SRST_BIT];
         next_ctrl[adas_pkg::CTRL_MEN_BIT] =
            pwdata[adas_pkg::CTRL_MEN_BIT];
         next_ctrl[adas_pkg::CTRL_SEN_BIT] =
            pwdata[adas_pkg::CTRL_SEN_BIT];
      end
      if (wr_en && paddr == adas_pkg::CFG_ADDR) begin
         next_cfg = pwdata[15:0] & 16'h3177;
      end
      if (rd_sel) begin
         next_pready = 1'b1;
         next_prdata = 32'h00000000;
         case (paddr)
            adas_pkg::CTRL_ADDR: next_prdata[15:0] = ctrl;
            adas_pkg::INT_ADDR: next_prdata[15:0] = intr;
            adas_pkg::CFG_ADDR: next_prdata[15:0] = cfg;
            adas_pkg::VALID_ADDR: begin
               next_prdata[adas_pkg::VAL_SOUT_BIT] = spk_out_valid;
               next_prdata[adas_pkg::VAL_SDMA_BIT] = spk_dma_valid;
               next_prdata[adas_pkg::VAL_MCAP_BIT] = mic_capture_valid;
               next_prdata[adas_pkg::VAL_MDMA_BIT] = mic_dma_valid;
            end
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= adas_pkg::CTRL_RST;
         cfg <= adas_pkg::CFG_RST;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         cfg <= next_cfg;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Interrupt flags: a hardware set wins over a same-cycle clear
   logic spk_tick, mic_tick, spk_under, mic_over, mic_move, mic_cap;
   always_comb begin
      next_intr = intr & ~w1c;
      if (spk_page2_evt & spk_run) next_intr[adas_pkg::INT_SPG2_BIT] = 1'b1;
      if (spk_page1_evt & spk_run) next_intr[adas_pkg::INT_SPG1_BIT] = 1'b1;
      if (spk_under) next_intr[adas_pkg::INT_SUND_BIT] = 1'b1;
      if (mic_page2_evt & mic_run) begin
         next_intr[adas_pkg::INT_MPG2_BIT] = 1'b1;
      end
      if (mic_page1_evt & mic_run) begin
         next_intr[adas_pkg::INT_MPG1_BIT] = 1'b1;
      end
      if (mic_over) next_intr[adas_pkg::INT_MOVR_BIT] = 1'b1;
      if (mic_move) next_intr[adas_pkg::INT_MRX_BIT] = 1'b1;
      next_intr = next_intr & 16'h0F0E;
      if (srst) next_intr = adas_pkg::INT_RST;
      next_irq = |next_intr;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         intr <= adas_pkg::INT_RST;
         irq <= 1'b0;
      end else begin
         intr <= next_intr;
         irq <= next_irq;
      end
   end

   // Speaker path
   always_comb begin
      next_dvref_cnt = dvref_cnt;
      if (!cfg[adas_pkg::CFG_DVREF_BIT]) begin
         next_dvref_cnt = '0;
      end else if (dvref_cnt != adas_pkg::SETTLE_CYC) begin
         next_dvref_cnt = dvref_cnt + TW'(1);
      end
      next_spk_run_q = spk_run;
      next_spk_out_valid = spk_out_valid;
      next_spk_dma_valid = spk_dma_valid;
      next_spk_out_reg = spk_out_reg;
      next_spk_dma_reg = spk_dma_reg;
      next_spk_primed = spk_primed;
      next_dac_data = dac_data;
      next_dac_load = 1'b0;
      next_spk_cnt = spk_cnt;
      spk_tick = 1'b0;
      spk_under = 1'b0;
      if (spk_run && !spk_run_q) begin
         // First sample waits out the reference settling if needed
         next_spk_cnt = adas_pkg::rate_cycles(cfg[2:0]);
         if (dvref_cnt != adas_pkg::SETTLE_CYC) begin
            next_spk_cnt = next_spk_cnt + adas_pkg::SETTLE_CYC;
         end
      end else if (spk_run) begin
         if (spk_cnt <= TW'(1)) begin
            spk_tick = 1'b1;
            next_spk_cnt = adas_pkg::rate_cycles(cfg[2:0]);
         end else begin
            next_spk_cnt = spk_cnt - TW'(1);
         end
      end
      if (spk_tick) begin
         if (spk_out_valid) begin
            next_dac_data = spk_out_reg;
            next_dac_load = 1'b1;
         end else begin
            spk_under = spk_primed;
         end
         next_spk_out_valid = 1'b0;
      end
      if (!next_spk_out_valid && spk_dma_valid) begin
         next_spk_out_reg = spk_dma_reg;
         next_spk_out_valid = 1'b1;
         next_spk_dma_valid = 1'b0;
         next_spk_primed = 1'b1;
      end
      if (spk_dma_req && spk_dma_ack) begin
         next_spk_dma_reg = spk_dma_data;
         next_spk_dma_valid = 1'b1;
      end
      next_spk_dma_req = spk_run && !spk_stall && !next_spk_dma_valid &&
                         !(spk_dma_req && spk_dma_ack);
      if (!spk_run) begin
         next_spk_out_valid = 1'b0;
         next_spk_dma_valid = 1'b0;
         next_spk_primed = 1'b0;
         next_spk_dma_req = 1'b0;
         next_spk_cnt = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dvref_cnt <= '0;
         spk_run_q <= 1'b0;
         spk_out_valid <= 1'b0;
         spk_dma_valid <= 1'b0;
         spk_out_reg <= 10'h000;
         spk_dma_reg <= 10'h000;
         spk_primed <= 1'b0;
         spk_cnt <= '0;
         dac_data <= 10'h000;
         dac_load <= 1'b0;
         spk_dma_req <= 1'b0;
         dac_vref_on <= 1'b0;
      end else begin
         dvref_cnt <= next_dvref_cnt;
         spk_run_q <= next_spk_run_q;
         spk_out_valid <= next_spk_out_valid;
         spk_dma_valid <= next_spk_dma_valid;
         spk_out_reg <= next_spk_out_reg;
         spk_dma_reg <= next_spk_dma_reg;
         spk_primed <= next_spk_primed;
         spk_cnt <= next_spk_cnt;
         dac_data <= next_dac_data;
         dac_load <= next_dac_load;
         spk_dma_req <= next_spk_dma_req;
         dac_vref_on <= next_cfg[adas_pkg::CFG_DVREF_BIT];
      end
   end

   // Converter inputs are asynchronous; data is stable before ack rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         adat_s1 <= 10'h000;
         adat_s2 <= 10'h000;
      end else begin
         ack_s1 <= adc_ack;
         ack_s2 <= ack_s1;
         adat_s1 <= adc_data;
         adat_s2 <= adat_s1;
      end
   end

   // Mic path
   always_comb begin
      next_avref_cnt = avref_cnt;
      if (!cfg[adas_pkg::CFG_AVREF_BIT]) begin
         next_avref_cnt = '0;
      end else if (avref_cnt != adas_pkg::SETTLE_CYC) begin
         next_avref_cnt = avref_cnt + TW'(1);
      end
      next_mic_run_q = mic_run;
      next_mic_cnt = mic_cnt;
      next_adc_st = adc_st;
      next_adc_request = adc_request;
      next_mic_capture_valid = mic_capture_valid;
      next_mic_capture_reg = mic_capture_reg;
      next_mic_dma_valid = mic_dma_valid;
      next_mic_dma_data = mic_dma_data;
      mic_tick = 1'b0;
      mic_cap = 1'b0;
      mic_over = 1'b0;
      mic_move = 1'b0;
      if (mic_run && !mic_run_q) begin
         next_mic_cnt = adas_pkg::rate_cycles(cfg[6:4]);
         if (avref_cnt != adas_pkg::SETTLE_CYC) begin
            next_mic_cnt = next_mic_cnt + adas_pkg::SETTLE_CYC;
         end
      end else if (mic_run) begin
         if (mic_cnt <= TW'(1)) begin
            mic_tick = 1'b1;
            next_mic_cnt = adas_pkg::rate_cycles(cfg[6:4]);
         end else begin
            next_mic_cnt = mic_cnt - TW'(1);
         end
      end
      // A late ack swallows the tick, so requests never pile up
      case (adc_st)
         adas_pkg::ADAS_ADC_IDLE: begin
            if (mic_tick) begin
               next_adc_st = adas_pkg::ADAS_ADC_REQ;
               next_adc_request = 1'b1;
            end
         end
         adas_pkg::ADAS_ADC_REQ: begin
            if (ack_s2) begin
               mic_cap = 1'b1;
               next_adc_request = 1'b0;
               next_adc_st = adas_pkg::ADAS_ADC_DONE;
            end
         end
         adas_pkg::ADAS_ADC_DONE: begin
            if (!ack_s2) next_adc_st = adas_pkg::ADAS_ADC_IDLE;
         end
         default: begin
            next_adc_st = adas_pkg::ADAS_ADC_IDLE;
            next_adc_request = 1'b0;
         end
      endcase
      if (mic_dma_req && mic_dma_ack) begin
         next_mic_dma_valid = 1'b0;
      end
      if (mic_capture_valid && !next_mic_dma_valid) begin
         mic_move = 1'b1;
         next_mic_dma_data = mic_capture_reg;
         next_mic_dma_valid = 1'b1;
         next_mic_capture_valid = 1'b0;
      end
      if (mic_cap) begin
         mic_over = mic_capture_valid & ~mic_move;
         next_mic_capture_reg = adat_s2;
         next_mic_capture_valid = 1'b1;
      end
      next_mic_dma_req = mic_run && !mic_stall && next_mic_dma_valid &&
                         !(mic_dma_req && mic_dma_ack);
      if (!mic_run) begin
         next_mic_capture_valid = 1'b0;
         next_mic_dma_valid = 1'b0;
         next_mic_dma_req = 1'b0;
         next_adc_request = 1'b0;
         next_adc_st = adas_pkg::ADAS_ADC_IDLE;
         next_mic_cnt = '0;
         mic_over = 1'b0;
         mic_move = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         avref_cnt <= '0;
         mic_run_q <= 1'b0;
         mic_cnt <= '0;
         adc_st <= adas_pkg::ADAS_ADC_IDLE;
         adc_request <= 1'b0;
         mic_capture_valid <= 1'b0;
         mic_capture_reg <= 10'h000;
         mic_dma_valid <= 1'b0;
         mic_dma_data <= 10'h000;
         mic_dma_req <= 1'b0;
         adc_vref_on <= 1'b0;
      end else begin
         avref_cnt <= next_avref_cnt;
         mic_run_q <= next_mic_run_q;
         mic_cnt <= next_mic_cnt;
         adc_st <= next_adc_st;
         adc_request <= next_adc_request;
         mic_capture_valid <= next_mic_capture_valid;
         mic_capture_reg <= next_mic_capture_reg;
         mic_dma_valid <= next_mic_dma_valid;
         mic_dma_data <= next_mic_dma_data;
         mic_dma_req <= next_mic_dma_req;
         adc_vref_on <= next_cfg[adas_pkg::CFG_AVREF_BIT];
      end
   end
endmodule

/* rtl/adas_pkg.sv */
// Constants, register map and rate decode for the audio sequencer.
// Assumes a 25 MHz APB clock; used by rtl/adas_top.sv only by scope.
package adas_pkg;
   // Register indices; byte address is four times the index
   localparam logic [31:0] VALID_IDX = 32'h0B000178;
   localparam logic [31:0] CTRL_IDX = 32'h0B00017A;
   localparam logic [31:0] INT_IDX = 32'h0B00017C;
   localparam logic [31:0] CFG_IDX = 32'h0B00017E;
   localparam logic [31:0] VALID_ADDR = {VALID_IDX[29:0], 2'b00};
   localparam logic [31:0] CTRL_ADDR = {CTRL_IDX[29:0], 2'b00};
   localparam logic [31:0] INT_ADDR = {INT_IDX[29:0], 2'b00};
   localparam logic [31:0] CFG_ADDR = {CFG_IDX[29:0], 2'b00};
   // Control fields
   localparam int CTRL_SRST_BIT = 15;
   localparam int CTRL_MEN_BIT = 4;
   localparam int CTRL_SEN_BIT = 0;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   // Interrupt status fields
   localparam int INT_MPG2_BIT = 11;
   localparam int INT_MPG1_BIT = 10;
   localparam int INT_MOVR_BIT = 9;
   localparam int INT_MRX_BIT = 8;
   localparam int INT_SPG2_BIT = 3;
   localparam int INT_SPG1_BIT = 2;
   localparam int INT_SUND_BIT = 1;
   localparam logic [15:0] INT_RST = 16'h0000;
   // Configuration fields
   localparam int CFG_SRATE_LSB = 0;
   localparam int CFG_MRATE_LSB = 4;
   localparam int CFG_MSTOP_BIT = 8;
   localparam int CFG_DVREF_BIT = 12;
   localparam int CFG_AVREF_BIT = 13;
   localparam logic [15:0] CFG_RST = 16'h0000;
   // Valid flag readback fields
   localparam int VAL_SOUT_BIT = 3;
   localparam int VAL_SDMA_BIT = 2;
   localparam int VAL_MCAP_BIT = 1;
   localparam int VAL_MDMA_BIT = 0;
   // Rate codes and rates in samples per 1000 s
   localparam logic [2:0] RATE_8K = 3'h4;
   localparam logic [2:0] RATE_44K = 3'h2;
   localparam logic [2:0] RATE_22K = 3'h1;
   localparam logic [2:0] RATE_11K = 3'h0;
   localparam longint SPS_8K = 64'd8000000;
   localparam longint SPS_44K = 64'd44100000;
   localparam longint SPS_22K = 64'd22050000;
   localparam longint SPS_11K = 64'd11025000;
   // Timing
   localparam longint CLK_HZ = 64'd25000000;
   localparam longint SETTLE_NS = 64'd5000;
   localparam int TW = 13;
   localparam logic [TW-1:0] SETTLE_CYC =
      TW'((SETTLE_NS * CLK_HZ + 64'd999999999) / 64'd1000000000);
   localparam logic [TW-1:0] PER_8K = TW'(CLK_HZ * 64'd1000 / SPS_8K);
   localparam logic [TW-1:0] PER_44K = TW'(CLK_HZ * 64'd1000 / SPS_44K);
   localparam logic [TW-1:0] PER_22K = TW'(CLK_HZ * 64'd1000 / SPS_22K);
   localparam logic [TW-1:0] PER_11K = TW'(CLK_HZ * 64'd1000 / SPS_11K);

   typedef enum logic [2:0] {
      ADAS_ADC_IDLE = 3'h1,
      ADAS_ADC_REQ = 3'h2,
      ADAS_ADC_DONE = 3'h4
   } adas_adc_t;

   // Reserved codes fall back to the slowest rate
   function automatic logic [TW-1:0] rate_cycles(input logic [2:0] sel);
      case (sel)
         RATE_44K: rate_cycles = PER_44K;
         RATE_22K: rate_cycles = PER_22K;
         RATE_11K: rate_cycles = PER_11K;
         default: rate_cycles = PER_8K;
      endcase
   endfunction
endpackage

/* dv/adas_top_properties.sv */
// Port checker for adas_top, bound into every instance of it.
// Assumes one pclk domain and the register map of adas_pkg.
`timescale 1ns/1ps
module adas_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic irq,
   input wire logic spk_dma_req,
   input wire logic spk_dma_ack,
   input wire logic dac_load,
   input wire logic adc_request,
   input wire logic adc_ack,
   input wire logic mic_dma_req,
   input wire logic mic_dma_ack,
   input wire logic [9:0] mic_dma_data
);
   logic ctrl_wr;
   logic rd_ctrl;
   logic rd_int;
   logic spk_on;
   assign ctrl_wr = psel && penable && pready && pwrite
      && paddr == adas_pkg::CTRL_ADDR;
   assign rd_ctrl = pready && !pwrite && paddr == adas_pkg::CTRL_ADDR;
   assign rd_int = pready && !pwrite && paddr == adas_pkg::INT_ADDR;
   // Tracks the stored speaker enable so a quick re-enable is no fault
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spk_on <= 1'b0;
      end else if (ctrl_wr) begin
         spk_on <= pwdata[0] && !pwdata[15];
      end
   end
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ctrl_rsvd_zero_a:
   assert property (rd_ctrl |-> prdata[31:16] == 16'h0000
      && prdata[14:5] == 10'h000 && prdata[3:1] == 3'h0)
      else $error("control reserved bits read non-zero");
   int_rsvd_zero_a:
   assert property (rd_int |-> prdata[31:12] == 20'h00000
      && prdata[7:4] == 4'h0 && !prdata[0])
      else $error("status reserved bits read non-zero");
   irq_follows_flags_a:
   assert property (rd_int && prdata[11:0] != 12'h000 |-> irq)
      else $error("flag set but irq low");
   dac_one_pulse_a:
   assert property (dac_load |=> !dac_load [*8])
      else $error("dac load longer than one cycle");
   spk_req_drop_a:
   assert property (spk_dma_req && spk_dma_ack |=> !spk_dma_req)
      else $error("speaker request held after ack");
   mic_data_hold_a:
   assert property (mic_dma_req && !mic_dma_ack
      |=> !mic_dma_req || $stable(mic_dma_data))
      else $error("mic data moved while request pending");
   adc_req_end_a:
   assert property (adc_request && adc_ack |-> ##[1:4] !adc_request)
      else $error("converter request not withdrawn after ack");
   srst_quiet_a:
   assert property (ctrl_wr && pwdata[15] |-> ##[1:3]
      (!irq && !spk_dma_req && !mic_dma_req && !adc_request))
      else $error("soft reset left a request or irq");
   spk_off_a:
   assert property (!spk_on ##1 !spk_on |-> !spk_dma_req && !dac_load)
      else $error("speaker active after disable");
endmodule
bind adas_top adas_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .irq, .spk_dma_req, .spk_dma_ack,
   .dac_load, .adc_request, .adc_ack, .mic_dma_req, .mic_dma_ack,
   .mic_dma_data);

/* dv/adas_far_model.sv */
// Far-side model: DMA unit of both paths and the A/D converter.
// Assumes the DMA handshakes of adas_top, all on pclk.
`timescale 1ns/1ps
module adas_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic spk_dma_req,
   output logic spk_dma_ack,
   output logic [9:0] spk_dma_data,
   input wire logic adc_request,
   output logic adc_ack,
   output logic [9:0] adc_data,
   input wire logic mic_dma_req,
   output logic mic_dma_ack,
   input wire logic [9:0] mic_dma_data,
   output logic [9:0] mic_last,
   output int mic_cnt
);
   logic [9:0] spk_seq;
   logic [9:0] adc_seq;
   logic tog;
   logic s_give;
   logic m_give;
   // Slow mode answers only on every other cycle
   assign s_give = spk_dma_req && !spk_dma_ack && (!slow || tog);
   assign m_give = mic_dma_req && !mic_dma_ack && (!slow || tog);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tog <= 1'b0;
         spk_dma_ack <= 1'b0;
         spk_dma_data <= 10'h3FF;
         spk_seq <= 10'h100;
         mic_dma_ack <= 1'b0;
         mic_last <= 10'h000;
         mic_cnt <= 0;
         adc_ack <= 1'b0;
         adc_data <= 10'h155;
         adc_seq <= 10'h200;
      end else begin
         tog <= !tog;
         spk_dma_ack <= s_give;
         // Data means nothing outside ack, so it toggles there
         spk_dma_data <= s_give ? spk_seq : ~spk_dma_data;
         if (spk_dma_req && spk_dma_ack) begin
            spk_seq <= spk_seq + 10'h001;
         end
         mic_dma_ack <= m_give;
         if (mic_dma_req && mic_dma_ack) begin
            mic_last <= mic_dma_data;
            mic_cnt <= mic_cnt + 1;
         end
         if (adc_request && !adc_ack) begin
            adc_ack <= 1'b1;
            adc_data <= adc_seq;
         end else if (!adc_request && adc_ack) begin
            adc_ack <= 1'b0;
            adc_data <= ~adc_data;
            adc_seq <= adc_seq + 10'h001;
         end
      end
   end
endmodule

/* dv/adas_top_tb_top.sv */
// Self-checking bench for adas_top over APB with the far-side model.
// Assumes the adas_pkg map and a 25 MHz pclk.
`timescale 1ns/1ps
module adas_top_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, slow = 1'b0, er;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic [3:0] pg = 4'h0;
   logic pready, pslverr, irq, dac_vref_on, adc_vref_on, dac_load;
   logic spk_dma_req, spk_dma_ack, adc_request, adc_ack;
   logic mic_dma_req, mic_dma_ack;
   logic [9:0] spk_dma_data, dac_data, adc_data, mic_dma_data, mic_last;
   int mic_cnt, failures = 0, checked = 0, t0, c0;
   localparam logic [31:0] A_CTRL = adas_pkg::CTRL_ADDR;
   localparam logic [31:0] A_INT = adas_pkg::INT_ADDR;
   localparam logic [31:0] A_VAL = adas_pkg::VALID_ADDR;
   localparam logic [31:0] A_CFG = adas_pkg::CFG_ADDR;
   localparam int PER [5] = '{566, 1133, 2267, 3125, 3125};
   localparam logic [31:0] CODE [5] = '{2, 1, 0, 4, 7};
   always #20 pclk = ~pclk;
   adas_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq, .dac_vref_on,
      .adc_vref_on, .spk_dma_req, .spk_dma_ack, .spk_dma_data,
      .spk_page1_evt(pg[0]), .spk_page2_evt(pg[1]), .dac_data, .dac_load,
      .adc_request, .adc_ack, .adc_data, .mic_dma_req, .mic_dma_ack,
      .mic_dma_data, .mic_page1_evt(pg[2]), .mic_page2_evt(pg[3]));
   adas_far_model u_far (.pclk, .presetn, .slow, .spk_dma_req,
      .spk_dma_ack, .spk_dma_data, .adc_request, .adc_ack, .adc_data,
      .mic_dma_req, .mic_dma_ack, .mic_dma_data, .mic_last, .mic_cnt);
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) chk("pready", 32'h0, 32'h1);
   endtask
   task automatic rdx(input logic [31:0] a, m, e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd & m, e);
   endtask
   // Counts edges up to the next load; bounded so a dead path fails
   task automatic wait_load(output int c);
      c = 0;
      do begin
         @(posedge pclk);
         #1;
         c++;
      end while (dac_load !== 1'b1 && c < 4000);
   endtask
   task automatic wait_mic(input int n);
      int k;
      k = 0;
      while (mic_cnt < n && k < 3000) begin
         @(posedge pclk);
         k++;
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge pclk);
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdx(A_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
      rdx(A_INT, 32'hFFFFFFFF, 32'h0, "int reset");
      rdx(A_VAL, 32'hFFFFFFFF, 32'h0, "valid reset");
      apb(1'b0, 32'h00000100, 32'h0);
      chk("unmapped", {rd[30:0], er}, 32'h1);
      apb(1'b1, A_CTRL, 32'h00007FEE);
      rdx(A_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reserved");
      apb(1'b1, A_INT, 32'h0000F0F1);
      rdx(A_INT, 32'hFFFFFFFF, 32'h0, "int reserved");
      for (int i = 0; i < 5; i++) begin
         slow <= (i == 1);
         apb(1'b1, A_CFG, 32'h1000 | CODE[i]);
         apb(1'b1, A_CTRL, 32'h1);
         wait_load(t0);
         if (i == 0) chk("late start", t0 > 680 && t0 < 700, 1);
         if (i > 0) chk("start", t0 > PER[i]-5 && t0 < PER[i]+5, 1);
         for (int k = 0; k < 2; k++) begin
            if (i == 0) chk("dac sample", dac_data, 32'h100 + k);
            wait_load(t0);
         end
         chk("interval", t0, PER[i]);
         apb(1'b1, A_CTRL, 32'h0);
      end
      slow <= 1'b0;
      rdx(A_INT, 32'h2, 32'h0, "no underrun");
      apb(1'b1, A_CFG, 32'h00003022);
      repeat (130) @(posedge pclk);
      chk("vref pins", {dac_vref_on, adc_vref_on}, 32'h3);
      apb(1'b1, A_CTRL, 32'h11);
      rdx(A_CTRL, 32'hFFFF, 32'h11, "enables");
      wait_mic(2);
      chk("mic sample", mic_last, 32'h201);
      rdx(A_INT, 32'h100, 32'h100, "rx done");
      chk("irq set", irq, 32'h1);
      apb(1'b1, A_INT, 32'h100);
      rdx(A_INT, 32'h100, 32'h0, "rx done clear");
      chk("irq clear", irq, 32'h0);
      pg <= 4'hF;
      @(posedge pclk);
      pg <= 4'h0;
      repeat (10) @(posedge pclk);
      c0 = mic_cnt;
      repeat (2400) @(posedge pclk);
      chk("mic held", mic_cnt, c0);
      chk("spk held", spk_dma_req, 32'h0);
      rdx(A_INT, 32'hE0E, 32'hE0E, "flags");
      rdx(A_VAL, 32'hF, 32'h3, "stalled valid");
      apb(1'b1, A_INT, 32'h4);
      rdx(A_INT, 32'hC, 32'h8, "one bit clear");
      apb(1'b1, A_INT, 32'h808);
      wait_load(t0);
      chk("spk resumes", t0 < 1300, 32'h1);
      wait_mic(c0 + 1);
      chk("mic resumes", mic_cnt > c0, 32'h1);
      apb(1'b1, A_CFG, 32'h00003122);
      repeat (10) @(posedge pclk);
      c0 = mic_cnt;
      repeat (1500) @(posedge pclk);
      chk("mic page stop", mic_cnt, c0);
      apb(1'b1, A_CTRL, 32'h0);
      rdx(A_VAL, 32'hF, 32'h0, "off valid");
      chk("irq held", irq, 32'h1);
      apb(1'b1, A_CTRL, 32'h8011);
      rdx(A_INT, 32'hFFFF, 32'h0, "soft reset int");
      chk("soft reset irq", irq, 32'h0);
      rdx(A_CTRL, 32'hFFFF, 32'h8011, "ctrl kept");
      apb(1'b1, A_CTRL, 32'h11);
      wait_load(t0);
      chk("after soft reset", t0 < 700, 32'h1);
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_CFG, 32'h0);
      tally_and_finish();
   end
endmodule
